//--- bench/dao_capture.sv
// Downstream capture model that latches both output buses on the ready clock.
`timescale 1ns/1ps
`include "dao_cfg.svh"
module dao_capture (
   input wire logic data_ready_clock,
   input wire logic data_ready_clock_oe,
   input wire logic [`DAO_BITS-1:0] first_output_bus,
   input wire logic first_output_bus_oe,
   input wire logic [`DAO_BITS-1:0] second_output_bus,
   input wire logic second_output_bus_oe,
   output logic [`DAO_BITS-1:0] cap_first_q,
   output logic [`DAO_BITS-1:0] cap_second_q,
   output int fall_count
);
   initial begin
      cap_first_q = '0;
      cap_second_q = '0;
      fall_count = 0;
   end
   // A released bus is taken as floating, so a stale word can never pass for a capture.
   always @(negedge data_ready_clock) begin
      if (data_ready_clock_oe === 1'b1) begin
         fall_count <= fall_count + 1;
         cap_first_q <= first_output_bus_oe ? first_output_bus : 'z;
         cap_second_q <= second_output_bus_oe ? second_output_bus : 'z;
      end
   end
endmodule // dao_capture

//--- bench/test_dual_adc_output_port.sv
// Self-checking bench for the dual converter output port.
`timescale 1ns/1ps
`include "dao_cfg.svh"
module test_dual_adc_output_port import dao_pkg::*; ;
   localparam int LAT = `DAO_LATENCY;
   localparam int SLP = 50;
   // One sample period of 125 ns spans this many system clocks.
   localparam int SPER = 25;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, sclk, sclk_run;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   dao_conv_t conv_a, conv_b;
   logic [11:0] first_output_bus, second_output_bus, cap_first, cap_second;
   logic first_output_bus_oe, second_output_bus_oe, range_flag, range_flag_oe;
   logic data_ready_clock, data_ready_clock_oe, dcs_enable;
   int fall_count, n_fail, check_count, n0;
   logic [31:0] rng_ctl [4] = '{32'h40, 32'h40, 32'h43, 32'h00};
   logic [13:0] rng_a [4] = '{14'h2555, 14'h1555, 14'h0555, 14'h2000};
   logic [13:0] rng_b [4] = '{14'h0AAA, 14'h0AAA, 14'h2AAA, 14'h1FFF};
   assign hready = hreadyout;
   dao_top #(.LATENCY(LAT), .SLEEP_CYCLES(SLP)) DUT (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .sample_clock_chan_a(sclk), .sample_clock_chan_b(sclk),
      .conv_a(conv_a), .conv_b(conv_b), .first_output_bus(first_output_bus),
      .first_output_bus_oe(first_output_bus_oe), .second_output_bus(second_output_bus),
      .second_output_bus_oe(second_output_bus_oe), .range_flag(range_flag),
      .range_flag_oe(range_flag_oe), .data_ready_clock(data_ready_clock),
      .data_ready_clock_oe(data_ready_clock_oe), .dcs_enable(dcs_enable));
   dao_capture cap (.data_ready_clock(data_ready_clock),
      .data_ready_clock_oe(data_ready_clock_oe), .first_output_bus(first_output_bus),
      .first_output_bus_oe(first_output_bus_oe), .second_output_bus(second_output_bus),
      .second_output_bus_oe(second_output_bus_oe), .cap_first_q(cap_first),
      .cap_second_q(cap_second), .fall_count(fall_count));
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   // Both sample clocks share one source, offset so it never lines up with the system clock.
   // The gate parks it low, so the stabilizer can be made to lose lock.
   initial begin
      sclk = 1'b0;
      #7.3;
      forever #62.5 sclk = ~sclk & sclk_run;
   end
   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(a, 1'b1, d, r);
      repeat (4) @(posedge hclk);
   endtask
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] r;
      bus(a, 1'b0, 32'h0, r);
      chk(r & m, e);
   endtask
   function automatic logic [11:0] fmt(input logic [1:0] m, input dao_conv_t c);
      logic [11:0] v;
      v = c.over ? `DAO_CODE_MAX : (c.under ? `DAO_CODE_MIN : c.code);
      if (m >= `DAO_LVL_TWO_THIRD) v[`DAO_MSB] = ~v[`DAO_MSB];
      return v;
   endfunction
   task automatic run_chk(input logic [31:0] ctl, input dao_conv_t a, input dao_conv_t b);
      logic [11:0] ea, eb;
      logic [31:0] r;
      ea = fmt(ctl[1:0], a);
      eb = fmt(ctl[1:0], b);
      bus(`DAO_CTRL_OFF, 1'b1, ctl, r);
      conv_a <= a;
      conv_b <= b;
      repeat ((LAT + 4) * SPER) @(posedge hclk);
      chk(first_output_bus, ctl[6] ? ea : eb);
      chk(second_output_bus, ctl[6] ? eb : ea);
      chk(range_flag, a.over | a.under | b.over | b.under);
      chk({cap_first, cap_second}, ctl[6] ? {ea, eb} : {eb, ea});
      chk({first_output_bus_oe, second_output_bus_oe, range_flag_oe}, 3'b111);
   endtask
   initial begin
      hresetn = 1'b0;
      sclk_run = 1'b1;
      hsel = 1'b0;
      haddr = '0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = '0;
      conv_a = '0;
      conv_b = '0;
      n_fail = 0;
      check_count = 0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      chk({first_output_bus_oe, second_output_bus_oe, range_flag_oe, data_ready_clock_oe,
           hreadyout, hresp}, 6'h02);
      rd_chk(`DAO_CTRL_OFF, 32'hFFFF_FFFF, `DAO_CTRL_RST);
      rd_chk(32'h0000_0010, 32'hFFFF_FFFF, 32'h0);
      run_chk(32'h40, {2'b00, 12'h123}, {2'b00, 12'hABC});
      rd_chk(`DAO_LASTA_OFF, 32'h1FFF, 32'h123);
      rd_chk(`DAO_LASTB_OFF, 32'h1FFF, 32'hABC);
      for (int m = 0; m < 4; m++) begin
         run_chk(32'h40 | m, {2'b00, 12'h7F1}, {2'b00, 12'h80E});
         chk(dcs_enable, m == 1 || m == 2);
         rd_chk(`DAO_STAT_OFF, 32'hC0, {24'h0, m == 1 || m == 2, m >= 2, 6'h0});
      end
      for (int i = 0; i < 4; i++) begin
         run_chk(rng_ctl[i], rng_a[i], rng_b[i]);
      end
      rd_chk(`DAO_STAT_OFF, 32'h240, 32'h200);
      run_chk(32'h00, {2'b00, 12'h123}, {2'b00, 12'hABC});
      n0 = fall_count;
      repeat (8 * SPER) @(posedge hclk);
      chk(32'(fall_count - n0), 32'd8);
      // Tracking mode: the swap follows the shared clock, A rides the first bus while it is high.
      wr(`DAO_CTRL_OFF, 32'h80);
      @(posedge data_ready_clock);
      repeat (3) @(negedge hclk);
      chk({first_output_bus, second_output_bus}, 24'h123ABC);
      @(negedge data_ready_clock);
      repeat (3) @(negedge hclk);
      chk({first_output_bus, second_output_bus}, 24'hABC123);
      wr(`DAO_CTRL_OFF, 32'h50);
      chk({first_output_bus_oe, range_flag_oe, second_output_bus_oe}, 3'b001);
      rd_chk(`DAO_STAT_OFF, 32'hF, 32'h0);
      wr(`DAO_CTRL_OFF, 32'h48);
      chk({first_output_bus_oe, second_output_bus_oe, data_ready_clock_oe}, 3'b100);
      chk(range_flag_oe, 1'b1);
      rd_chk(`DAO_STAT_OFF, 32'hF, 32'h4);
      wr(`DAO_CTRL_OFF, 32'h54);
      chk({first_output_bus_oe, range_flag_oe, second_output_bus_oe}, 3'b001);
      chk(data_ready_clock_oe, 1'b1);
      rd_chk(`DAO_STAT_OFF, 32'hF, 32'h2);
      wr(`DAO_CTRL_OFF, 32'h40);
      rd_chk(`DAO_STAT_OFF, 32'h30, 32'h0);
      repeat (SLP + 10) @(posedge hclk);
      rd_chk(`DAO_STAT_OFF, 32'h30, 32'h10);
      repeat (55 * SPER) @(posedge hclk);
      rd_chk(`DAO_STAT_OFF, 32'h30, 32'h10);
      repeat (55 * SPER) @(posedge hclk);
      rd_chk(`DAO_STAT_OFF, 32'h30, 32'h30);
      wr(`DAO_CTRL_OFF, 32'h41);
      repeat (105 * SPER) @(posedge hclk);
      rd_chk(`DAO_STAT_OFF, 32'h1F0, 32'h1B0);
      sclk_run <= 1'b0;
      repeat (300) @(posedge hclk);
      rd_chk(`DAO_STAT_OFF, 32'h1F0, 32'h80);
      sclk_run <= 1'b1;
      repeat (90 * SPER) @(posedge hclk);
      rd_chk(`DAO_STAT_OFF, 32'h1F0, 32'h80);
      repeat (15 * SPER) @(posedge hclk);
      rd_chk(`DAO_STAT_OFF, 32'h1F0, 32'h1B0);
      wrap_up();
   end
   // The whole sequence needs roughly 11000 clocks; over three times that means a hang.
   initial begin
      repeat (40000) @(posedge hclk);
      n_fail++;
      wrap_up();
   end
endmodule // test_dual_adc_output_port

//--- logic/dao_chan.sv
// One converter channel: power mode, recovery timing and output pipeline.
`timescale 1ns/1ps
`include "dao_cfg.svh"
module dao_chan
   import dao_pkg::*;
#(
   parameter int LATENCY = `DAO_LATENCY,
   parameter int SLEEP_CYCLES = `DAO_SLEEP_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic strobe,
   input wire dao_conv_t conv,
   input wire logic power_down,
   input wire logic output_enable_n,
   output dao_word_t word,
   output dao_pwr_t pwr,
   output logic valid
);
   localparam int CW = $clog2(SLEEP_CYCLES + `DAO_NAP_CYC + 1);
   dao_pwr_t pwr_q;
   dao_pwr_t pwr_d;
   logic [CW-1:0] rec_q;
   logic rec_hclk_q;
   dao_word_t sat;
   dao_word_t pipe_q [LATENCY];

   // Only this channel's own pins decide its mode.
   always_comb begin
      if (!power_down) begin
         pwr_d = DAO_NORMAL;
      end else if (output_enable_n) begin
         pwr_d = DAO_SLEEP;
      end else begin
         pwr_d = DAO_NAP;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pwr_q <= DAO_NORMAL;
      end else begin
         pwr_q <= pwr_d;
      end
   end

   // Sleep recovery counts system cycles, nap recovery counts sample clocks.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rec_q <= '0;
         rec_hclk_q <= 1'b0;
      end else if (pwr_q != DAO_NORMAL && pwr_d == DAO_NORMAL) begin
         rec_hclk_q <= (pwr_q == DAO_SLEEP);
         rec_q <= (pwr_q == DAO_SLEEP) ? CW'(SLEEP_CYCLES) : CW'(`DAO_NAP_CYC);
      end else if (rec_q != '0 && (rec_hclk_q || strobe)) begin
         rec_q <= rec_q - 1'b1;
      end
   end

   always_comb begin
      sat.rng = conv.over | conv.under;
      if (conv.over) begin
         sat.code = `DAO_CODE_MAX;
      end else if (conv.under) begin
         sat.code = `DAO_CODE_MIN;
      end else begin
         sat.code = conv.code;
      end
   end

   // The pipeline freezes in low power, as the converter core is off.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < LATENCY; i++) begin
            pipe_q[i] <= '0;
         end
      end else if (strobe && pwr_q == DAO_NORMAL) begin
         pipe_q[0] <= sat;
         for (int i = 1; i < LATENCY; i++) begin
            pipe_q[i] <= pipe_q[i-1];
         end
      end
   end

   assign word = pipe_q[LATENCY-1];
   assign pwr = pwr_q;
   assign valid = (pwr_q == DAO_NORMAL) && (rec_q == '0);

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_clamp_over: assert property (
      strobe && conv.over && pwr_q == DAO_NORMAL
      |=> pipe_q[0].code == `DAO_CODE_MAX && pipe_q[0].rng)
      else $error("overrange not clamped to top code");
   a_clamp_under: assert property (
      strobe && conv.under && !conv.over && pwr_q == DAO_NORMAL
      |=> pipe_q[0].code == `DAO_CODE_MIN && pipe_q[0].rng)
      else $error("underrange not clamped to bottom code");
   a_sleep_entry: assert property (
      power_down && output_enable_n |=> pwr_q == DAO_SLEEP)
      else $error("sleep mode not entered");
   a_nap_recover: assert property (
      pwr_q == DAO_NAP && pwr_d == DAO_NORMAL
      |=> !valid && rec_q == CW'(`DAO_NAP_CYC) && !rec_hclk_q)
      else $error("nap recovery not started");
endmodule // dao_chan

//--- logic/dao_top.sv
// Dual converter output port with AHB-Lite control registers.
`timescale 1ns/1ps
`include "dao_cfg.svh"
module dao_top
   import dao_pkg::*;
#(
   parameter int LATENCY = `DAO_LATENCY,
   parameter int SLEEP_CYCLES = `DAO_SLEEP_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic sample_clock_chan_a,
   input wire logic sample_clock_chan_b,
   input wire dao_conv_t conv_a,
   input wire dao_conv_t conv_b,
   output logic [`DAO_BITS-1:0] first_output_bus,
   output logic first_output_bus_oe,
   output logic [`DAO_BITS-1:0] second_output_bus,
   output logic second_output_bus_oe,
   output logic range_flag,
   output logic range_flag_oe,
   output logic data_ready_clock,
   output logic data_ready_clock_oe,
   output logic dcs_enable
);
   localparam int LOCK_W = $clog2(`DAO_LOCK_CYC + 1);
   localparam int STOP_W = $clog2(`DAO_STOP_CYC + 1);

   // Bus slave state.
   logic [31:0] ctrl_q;
   logic [31:0] ctrl_view;
   logic [31:0] rdata_d;
   logic [31:0] hrdata_q;
   logic [7:0] waddr_q;
   logic wpend_q;
   logic take;

   // Pin synchronisers.
   logic ca_s1_q;
   logic ca_s2_q;
   logic ca_s3_q;
   logic cb_s1_q;
   logic cb_s2_q;
   logic cb_s3_q;
   dao_conv_t conv_a_s1_q;
   dao_conv_t conv_a_s2_q;
   dao_conv_t conv_b_s1_q;
   dao_conv_t conv_b_s2_q;
   logic strobe_a;
   logic strobe_b;

   // Channel state.
   dao_word_t word_a;
   dao_word_t word_b;
   dao_pwr_t pwr_a;
   dao_pwr_t pwr_b;
   logic valid_a;
   logic valid_b;

   // Mode decode and stabilizer lock tracking.
   logic [1:0] mode_lvl;
   logic twos;
   logic dcs_on;
   logic swap;
   logic [STOP_W-1:0] idle_q;
   logic [LOCK_W-1:0] lock_q;
   logic locked;

   // Output flops.
   dao_bus_t first_q;
   dao_bus_t second_q;
   logic range_q;
   logic range_oe_q;
   logic drc_q;
   logic drc_oe_q;
   logic dcs_q;

   function automatic logic [`DAO_BITS-1:0] fmt(input logic [`DAO_BITS-1:0] c,
                                                input logic tc);
      fmt = c;
      if (tc) begin
         fmt[`DAO_MSB] = ~c[`DAO_MSB];
      end
   endfunction

   // AHB-Lite slave: zero wait states, every answer OKAY.
   assign take = hsel && hready && htrans[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wpend_q <= 1'b0;
         waddr_q <= '0;
      end else begin
         wpend_q <= take && hwrite;
         if (take) begin
            waddr_q <= haddr[7:0];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= `DAO_CTRL_RST;
      end else if (wpend_q && waddr_q == `DAO_CTRL_OFF) begin
         ctrl_q <= hwdata & `DAO_CTRL_MASK;
      end
   end

   // A read right behind a write to the same word sees the new value.
   always_comb begin
      if (wpend_q && waddr_q == `DAO_CTRL_OFF) begin
         ctrl_view = hwdata & `DAO_CTRL_MASK;
      end else begin
         ctrl_view = ctrl_q;
      end
   end

   always_comb begin
      rdata_d = '0;
      unique case (haddr[7:0])
         `DAO_CTRL_OFF: begin
            rdata_d = ctrl_view;
         end
         `DAO_STAT_OFF: begin
            rdata_d[`DAO_S_PWRA +: 2] = pwr_a;
            rdata_d[`DAO_S_PWRB +: 2] = pwr_b;
            rdata_d[`DAO_S_VALA] = valid_a && (locked || !dcs_on);
            rdata_d[`DAO_S_VALB] = valid_b && (locked || !dcs_on);
            rdata_d[`DAO_S_TWOS] = twos;
            rdata_d[`DAO_S_DCS] = dcs_on;
            rdata_d[`DAO_S_LOCK] = locked;
            rdata_d[`DAO_S_RANGE] = range_q;
         end
         `DAO_LASTA_OFF: begin
            rdata_d[`DAO_BITS] = word_a.rng;
            rdata_d[`DAO_BITS-1:0] = fmt(word_a.code, twos);
         end
         `DAO_LASTB_OFF: begin
            rdata_d[`DAO_BITS] = word_b.rng;
            rdata_d[`DAO_BITS-1:0] = fmt(word_b.code, twos);
         end
         default: begin
            rdata_d = '0;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= '0;
      end else if (take && !hwrite) begin
         hrdata_q <= rdata_d;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   assign hrdata = hrdata_q;

   // Two flops before any logic; the third feeds edge detection and, for channel B, the ready clock.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ca_s1_q <= 1'b0;
         ca_s2_q <= 1'b0;
         ca_s3_q <= 1'b0;
         cb_s1_q <= 1'b0;
         cb_s2_q <= 1'b0;
         cb_s3_q <= 1'b0;
      end else begin
         ca_s1_q <= sample_clock_chan_a;
         ca_s2_q <= ca_s1_q;
         ca_s3_q <= ca_s2_q;
         cb_s1_q <= sample_clock_chan_b;
         cb_s2_q <= cb_s1_q;
         cb_s3_q <= cb_s2_q;
      end
   end

   // Converter words take the same two flops so they stay aligned
   // with the clock edge that samples them.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         conv_a_s1_q <= '0;
         conv_a_s2_q <= '0;
         conv_b_s1_q <= '0;
         conv_b_s2_q <= '0;
      end else begin
         conv_a_s1_q <= conv_a;
         conv_a_s2_q <= conv_a_s1_q;
         conv_b_s1_q <= conv_b;
         conv_b_s2_q <= conv_b_s1_q;
      end
   end

   assign strobe_a = ca_s2_q && !ca_s3_q;
   assign strobe_b = cb_s2_q && !cb_s3_q;

   dao_chan #(
      .LATENCY(LATENCY),
      .SLEEP_CYCLES(SLEEP_CYCLES)
   ) u_chan_a (
      .hclk(hclk),
      .hresetn(hresetn),
      .strobe(strobe_a),
      .conv(conv_a_s2_q),
      .power_down(ctrl_q[`DAO_F_PDA]),
      .output_enable_n(ctrl_q[`DAO_F_OENA]),
      .word(word_a),
      .pwr(pwr_a),
      .valid(valid_a)
   );

   dao_chan #(
      .LATENCY(LATENCY),
      .SLEEP_CYCLES(SLEEP_CYCLES)
   ) u_chan_b (
      .hclk(hclk),
      .hresetn(hresetn),
      .strobe(strobe_b),
      .conv(conv_b_s2_q),
      .power_down(ctrl_q[`DAO_F_PDB]),
      .output_enable_n(ctrl_q[`DAO_F_OENB]),
      .word(word_b),
      .pwr(pwr_b),
      .valid(valid_b)
   );

   assign mode_lvl = ctrl_q[`DAO_F_MODE +: 2];
   assign twos = (mode_lvl == `DAO_LVL_TWO_THIRD) || (mode_lvl == `DAO_LVL_VDD);
   assign dcs_on = (mode_lvl == `DAO_LVL_THIRD) || (mode_lvl == `DAO_LVL_TWO_THIRD);

   // Tracking mode lets the swap follow channel A's clock for interleaving.
   assign swap = ctrl_q[`DAO_F_TRACK] ? ca_s2_q : ctrl_q[`DAO_F_SWAP];

   // A stopped channel A sample clock drops lock; it returns after a run of its edges.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         idle_q <= '0;
      end else if (strobe_a) begin
         idle_q <= '0;
      end else if (idle_q != STOP_W'(`DAO_STOP_CYC)) begin
         idle_q <= idle_q + 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lock_q <= '0;
      end else if (!dcs_on || idle_q == STOP_W'(`DAO_STOP_CYC)) begin
         lock_q <= '0;
      end else if (strobe_a && !locked) begin
         lock_q <= lock_q + 1'b1;
      end
   end

   assign locked = (lock_q == LOCK_W'(`DAO_LOCK_CYC));

   // First bus follows channel A's enable, second bus channel B's.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         first_q <= '0;
         second_q <= '0;
      end else begin
         if (swap) begin
            first_q.data <= fmt(word_a.code, twos);
            second_q.data <= fmt(word_b.code, twos);
         end else begin
            first_q.data <= fmt(word_b.code, twos);
            second_q.data <= fmt(word_a.code, twos);
         end
         first_q.oe <= pwr_a == DAO_NORMAL && !ctrl_q[`DAO_F_OENA];
         second_q.oe <= pwr_b == DAO_NORMAL && !ctrl_q[`DAO_F_OENB];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         range_q <= 1'b0;
         range_oe_q <= 1'b0;
      end else begin
         range_q <= word_a.rng || word_b.rng;
         range_oe_q <= pwr_a == DAO_NORMAL && !ctrl_q[`DAO_F_OENA];
      end
   end

   // One flop behind the edge detector, so the clock rises with new data
   // and falls half a sample period later, when the data is settled.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         drc_q <= 1'b0;
         drc_oe_q <= 1'b0;
         dcs_q <= 1'b0;
      end else begin
         drc_q <= cb_s3_q;
         drc_oe_q <= pwr_b == DAO_NORMAL;
         dcs_q <= dcs_on;
      end
   end

   assign first_output_bus = first_q.data;
   assign first_output_bus_oe = first_q.oe;
   assign second_output_bus = second_q.data;
   assign second_output_bus_oe = second_q.oe;
   assign range_flag = range_q;
   assign range_flag_oe = range_oe_q;
   assign data_ready_clock = drc_q;
   assign data_ready_clock_oe = drc_oe_q;
   assign dcs_enable = dcs_q;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_rise_b;
      strobe_b;
   endsequence

   sequence s_clk_out_up;
      !drc_q ##1 drc_q;
   endsequence

   a_range_shared: assert property (
      (word_a.rng || word_b.rng) |=> range_flag)
      else $error("range flag missed an out-of-range word");
   a_offset_code: assert property (
      !twos && swap |=> first_output_bus == $past(word_a.code))
      else $error("offset binary code wrong");
   a_twos_code: assert property (
      twos && swap |=> first_output_bus[`DAO_MSB] == !$past(word_a.code[`DAO_MSB])
      && first_output_bus[`DAO_MSB-1:0] == $past(word_a.code[`DAO_MSB-1:0]))
      else $error("two's complement code wrong");
   a_swap_low: assert property (
      !swap && !twos |=> second_output_bus == $past(word_a.code)
      && first_output_bus == $past(word_b.code))
      else $error("bus swap low routed wrongly");
   a_range_off: assert property (
      pwr_a != DAO_NORMAL |=> !range_flag_oe)
      else $error("range flag driven in low power");
   a_clk_out_off: assert property (
      pwr_b != DAO_NORMAL |=> !data_ready_clock_oe)
      else $error("ready clock driven in low power");
   a_clk_out_copy: assert property (
      s_rise_b |-> ##1 s_clk_out_up)
      else $error("ready clock does not follow channel B clock");
   a_oe_float: assert property (
      ctrl_q[`DAO_F_OENA] |=> !first_output_bus_oe && !range_flag_oe)
      else $error("channel A outputs driven while disabled");
   a_dcs_level: assert property (
      mode_lvl == `DAO_LVL_VDD || mode_lvl == `DAO_LVL_GND |=> !dcs_enable)
      else $error("stabilizer on at a rail level");
   a_lock_drop: assert property (
      dcs_on && idle_q == STOP_W'(`DAO_STOP_CYC) |=> !locked [*2])
      else $error("stabilizer stayed locked on a stopped clock");
endmodule // dao_top

//--- pkg/dao_cfg.svh
// Constants for the dual converter output port.
`ifndef DAO_CFG_SVH
`define DAO_CFG_SVH
`define DAO_BITS 12
`define DAO_CODE_MAX 12'hFFF
`define DAO_CODE_MIN 12'h000
`define DAO_MSB 11
`define DAO_LVL_GND 2'h0
`define DAO_LVL_THIRD 2'h1
`define DAO_LVL_TWO_THIRD 2'h2
`define DAO_LVL_VDD 2'h3
`define DAO_CTRL_OFF 8'h00
`define DAO_STAT_OFF 8'h04
`define DAO_LASTA_OFF 8'h08
`define DAO_LASTB_OFF 8'h0C
`define DAO_CTRL_MASK 32'h0000_00FF
`define DAO_CTRL_RST 32'h0000_0030
`define DAO_F_MODE 0
`define DAO_F_PDA 2
`define DAO_F_PDB 3
`define DAO_F_OENA 4
`define DAO_F_OENB 5
`define DAO_F_SWAP 6
`define DAO_F_TRACK 7
`define DAO_S_PWRA 0
`define DAO_S_PWRB 2
`define DAO_S_VALA 4
`define DAO_S_VALB 5
`define DAO_S_TWOS 6
`define DAO_S_DCS 7
`define DAO_S_LOCK 8
`define DAO_S_RANGE 9
`define DAO_CLK_MHZ 200
`define DAO_SLEEP_MS 1
`define DAO_SLEEP_CYC (`DAO_SLEEP_MS * 1000 * `DAO_CLK_MHZ)
`define DAO_NAP_CYC 100
`define DAO_LOCK_CYC 100
`define DAO_STOP_NS 1000
`define DAO_STOP_CYC ((`DAO_STOP_NS * `DAO_CLK_MHZ) / 1000)
`define DAO_LATENCY 5
`endif

//--- pkg/dao_pkg.sv
// Types shared by the dual converter output port.
`include "dao_cfg.svh"
package dao_pkg;
   typedef enum logic [1:0] {DAO_NORMAL, DAO_NAP, DAO_SLEEP} dao_pwr_t;
   typedef struct packed {
      logic over;
      logic under;
      logic [`DAO_BITS-1:0] code;
   } dao_conv_t;
   typedef struct packed {
      logic rng;
      logic [`DAO_BITS-1:0] code;
   } dao_word_t;
   typedef struct packed {
      logic [`DAO_BITS-1:0] data;
      logic oe;
   } dao_bus_t;
endpackage
